// ### inc/pwm_consts.svh
// Constants of the multichannel pulse-width generator
// What this block does
// - Eight programmable pulse-width channels, numbered one through eight.
// - Cycle period and high time are both counted in microseconds.
// - All channels share one period, the value given by the latest accepted command other than a release.
// - With timer interrupts in use, only channels one to four are available; one to three in the reduced variant.
// - Programming a channel turns its pin into an output.
// - A programmed channel runs on alone until reprogrammed or reset.
// - Output is high for the high time, low for the rest of the period.
// - High time of minus one leaves the pin as plain digital I/O.
// - The reduced variant offers only six usable channels.
// - Reduced variant keeps eight-channel numbering; two numbers have no pin.
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH
`define CLK_FREQ_HZ 20000000
`define HZ_PER_MHZ 1000000
`define CYC_PER_US (`CLK_FREQ_HZ / `HZ_PER_MHZ)
`define NUM_CHANNELS 8
`define TIME_W 16
`define HIGH_W 17
`define HIGH_RELEASE 17'h1FFFF
`define CHAN_FIRST 4'h1
`define CHAN_LAST 4'h8
`define TIMER_CHANNELS 4'h4
`define REDUCED_CHANNELS 6
`define REDUCED_NOPIN_MASK 8'h28
`define TIMER_MASK 8'h0F
`endif

// ### inc/pwm_pkg.sv
// Types shared by the pulse-width generator files
package pwm_pkg;
	typedef logic [15:0] us_time_type;
	typedef logic [4:0] prescale_type;
	typedef enum logic [1:0] {RES_NONE, RES_DONE, RES_REFUSED} cmd_result_type;
endpackage

// ### rtl/pwm_channel.sv
// One pulse-width output channel with its own high time
`include "pwm_consts.svh"
module pwm_channel (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Command for this channel
	input wire logic load_i,
	input wire logic release_i,
	input wire logic allowed_i,
	input wire pwm_pkg::us_time_type high_us_i,
	// Shared microsecond position in the period
	input wire pwm_pkg::us_time_type us_count_i,
	// Pin side
	output logic pwm_o,
	output logic select_o
);
	logic active_ff;
	logic nxt_active;
	pwm_pkg::us_time_type high_ff;
	pwm_pkg::us_time_type nxt_high;
	logic pwm_ff;
	logic nxt_pwm;
	logic sel_ff;
	logic nxt_sel;

	// Program, release or keep; the waveform itself needs no software
	always_comb begin
		nxt_active = active_ff;
		nxt_high = high_ff;
		if (load_i) begin
			nxt_active = ~release_i;
			if (!release_i) begin
				nxt_high = high_us_i;
			end
		end
		nxt_sel = nxt_active & allowed_i;
		// Zero high time never beats the count, so the pin stays low
		nxt_pwm = nxt_sel & (us_count_i < nxt_high);
	end

	// State registers
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			active_ff <= 1'b0;
			high_ff <= 16'h0000;
			pwm_ff <= 1'b0;
			sel_ff <= 1'b0;
		end else begin
			active_ff <= nxt_active;
			high_ff <= nxt_high;
			pwm_ff <= nxt_pwm;
			sel_ff <= nxt_sel;
		end
	end

	assign pwm_o = pwm_ff;
	assign select_o = sel_ff;

	sequence s_program;
		load_i && !release_i && allowed_i;
	endsequence

	a_load_drives: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_program |=> select_o ##1 (select_o || $past(load_i) || !$past(allowed_i)))
		else $error("programmed channel did not take its pin");
	a_release_frees: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		load_i && release_i |=> !select_o && !pwm_o)
		else $error("released channel still drives its pin");
	a_keeps_running: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		active_ff && allowed_i && !load_i |=> select_o && active_ff)
		else $error("running channel stopped on its own");
	a_high_window: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		active_ff && allowed_i && !load_i && us_count_i < high_ff |=> pwm_o)
		else $error("output low inside the high time");
	a_low_remainder: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!load_i && us_count_i >= high_ff |=> !pwm_o)
		else $error("output high after the high time");
	a_zero_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!load_i && high_ff == 16'h0000 |=> !pwm_o)
		else $error("zero high time gave a high output");
endmodule

// ### rtl/multichannel_hw_pwm.sv
// Multichannel pulse-width generator: command decode, shared period, channels
`include "pwm_consts.svh"
module multichannel_hw_pwm #(
	parameter bit REDUCED_VARIANT = 1'b0
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Software command, same clock domain
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_channel_i,
	input wire pwm_pkg::us_time_type cmd_cycle_us_i,
	input wire logic [16:0] cmd_high_us_i,
	// Timer interrupt facility in use, asynchronous level
	input wire logic timer_irq_mode_i,
	// Command status
	output logic cmd_done_o,
	output logic cmd_refused_o,
	output pwm_pkg::us_time_type cycle_us_o,
	// Pin side
	output logic [7:0] pwm_o,
	output logic [7:0] pin_function_select_o
);
	// Timer mode synchroniser
	logic tmr_meta_ff;
	logic tmr_sync_ff;
	logic nxt_tmr_meta;
	logic nxt_tmr_sync;

	// Microsecond prescaler and shared period position
	pwm_pkg::prescale_type pre_ff;
	pwm_pkg::prescale_type nxt_pre;
	pwm_pkg::us_time_type us_cnt_ff;
	pwm_pkg::us_time_type nxt_us_cnt;
	pwm_pkg::us_time_type period_ff;
	pwm_pkg::us_time_type nxt_period;
	logic us_tick;
	logic [16:0] us_next_wide;

	// Command decode
	logic done_ff;
	logic refused_ff;
	logic nxt_done;
	logic nxt_refused;
	pwm_pkg::cmd_result_type nxt_res;
	logic [7:0] allowed;
	logic [7:0] chan_onehot;
	logic [7:0] load;
	logic in_range;
	logic high_ok;
	logic release_req;
	logic cmd_ok;

	// Level from a pin: two flops before anything looks at it
	always_comb begin
		nxt_tmr_meta = timer_irq_mode_i;
		nxt_tmr_sync = tmr_meta_ff;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tmr_meta_ff <= 1'b0;
			tmr_sync_ff <= 1'b0;
		end else begin
			tmr_meta_ff <= nxt_tmr_meta;
			tmr_sync_ff <= nxt_tmr_sync;
		end
	end

	// Which channel numbers have a usable output in the present setup
	always_comb begin
		allowed = 8'hFF;
		if (REDUCED_VARIANT) begin
			allowed = allowed & ~`REDUCED_NOPIN_MASK;
		end
		if (tmr_sync_ff) begin
			allowed = allowed & `TIMER_MASK;
		end
	end

	// Validate the command; refused commands change nothing
	always_comb begin
		in_range = (cmd_channel_i >= `CHAN_FIRST) && (cmd_channel_i <= `CHAN_LAST);
		chan_onehot = 8'h00;
		if (in_range) begin
			chan_onehot = 8'h01 << (cmd_channel_i - `CHAN_FIRST);
		end
		release_req = (cmd_high_us_i == `HIGH_RELEASE);
		// Other negative high times have no meaning and are refused
		high_ok = release_req | ~cmd_high_us_i[16];
		cmd_ok = cmd_valid_i & in_range & high_ok & |(chan_onehot & allowed);
		load = cmd_ok ? chan_onehot : 8'h00;
	end

	// Command result, decoded ahead of the flops so both status pins leave a register
	always_comb begin
		nxt_res = pwm_pkg::RES_NONE;
		if (cmd_valid_i) begin
			nxt_res = cmd_ok ? pwm_pkg::RES_DONE : pwm_pkg::RES_REFUSED;
		end
		case (nxt_res)
			pwm_pkg::RES_DONE: begin
				nxt_done = 1'b1;
				nxt_refused = 1'b0;
			end
			pwm_pkg::RES_REFUSED: begin
				nxt_done = 1'b0;
				nxt_refused = 1'b1;
			end
			default: begin
				nxt_done = 1'b0;
				nxt_refused = 1'b0;
			end
		endcase
	end

	// One cycle pulses: an idle cycle or the next command overwrites them
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			done_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			done_ff <= nxt_done;
			refused_ff <= nxt_refused;
		end
	end

	// Status pins straight from their flops
	assign cmd_done_o = done_ff;
	assign cmd_refused_o = refused_ff;

	// Time base: one tick per microsecond, period position wraps at the shared period
	always_comb begin
		us_tick = (pre_ff == 5'(`CYC_PER_US - 1));
		nxt_pre = us_tick ? 5'h00 : pre_ff + 5'h01;
		us_next_wide = {1'b0, us_cnt_ff} + 17'h00001;
		nxt_us_cnt = us_cnt_ff;
		if (us_tick) begin
			nxt_us_cnt = (us_next_wide >= {1'b0, period_ff}) ? 16'h0000 : us_next_wide[15:0];
		end
		// Any accepted command other than a release sets the one period for every channel
		nxt_period = period_ff;
		if (cmd_ok && !release_req) begin
			nxt_period = cmd_cycle_us_i;
		end
	end

	// The running count is not restarted on a new period, so other channels keep phase
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pre_ff <= 5'h00;
			us_cnt_ff <= 16'h0000;
			period_ff <= 16'h0000;
		end else begin
			pre_ff <= nxt_pre;
			us_cnt_ff <= nxt_us_cnt;
			period_ff <= nxt_period;
		end
	end

	assign cycle_us_o = period_ff;

	// One channel instance per output pin
	genvar ch;
	generate
		for (ch = 0; ch < `NUM_CHANNELS; ch++) begin : g_chan
			pwm_channel u_chan (
				.clk_sys_i(clk_sys_i),
				.rst_i(rst_i),
				.load_i(load[ch]),
				.release_i(release_req),
				.allowed_i(allowed[ch]),
				.high_us_i(cmd_high_us_i[15:0]),
				.us_count_i(us_cnt_ff),
				.pwm_o(pwm_o[ch]),
				.select_o(pin_function_select_o[ch])
			);
		end
	endgenerate

	sequence s_good_cmd;
		cmd_ok && !release_req;
	endsequence

	a_period_latched: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_good_cmd |=> cycle_us_o == $past(cmd_cycle_us_i) && cmd_done_o)
		else $error("period not taken from the latest command");
	a_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		us_tick |=> !us_tick [*8] ##1 !us_tick [*8] ##1 !us_tick [*3]
		##1 us_tick)
		else $error("microsecond tick not every twenty cycles");
	a_count_steps: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		us_tick && ({1'b0, us_cnt_ff} + 17'h00001 < {1'b0, period_ff}) |=> us_cnt_ff == $past(us_cnt_ff) + 16'h0001)
		else $error("period position did not advance");
	a_count_wraps: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		us_tick && ({1'b0, us_cnt_ff} + 17'h00001 >= {1'b0, period_ff}) |=> us_cnt_ff == 16'h0000)
		else $error("period position did not wrap");
	a_range_refused: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cmd_valid_i && (cmd_channel_i == 4'h0 || cmd_channel_i > 4'h8) |=> cmd_refused_o && !cmd_done_o)
		else $error("channel number outside one to eight accepted");
	a_timer_limit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		tmr_sync_ff |=> pin_function_select_o[7:4] == 4'h0)
		else $error("upper channel active while timer mode in use");
	a_six_usable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		REDUCED_VARIANT |-> $countones(pin_function_select_o) <= 6)
		else $error("reduced variant drove more than six channels");
	a_no_pin: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		REDUCED_VARIANT && cmd_valid_i && (cmd_channel_i == 4'h4 || cmd_channel_i == 4'h6) |=> cmd_refused_o)
		else $error("pinless channel accepted in reduced variant");
	a_status_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cmd_ok |=> cmd_done_o && !cmd_refused_o)
		else $error("accepted command gave no done pulse");
	a_bad_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cmd_valid_i && cmd_high_us_i[16] && cmd_high_us_i != `HIGH_RELEASE |=> cmd_refused_o && !cmd_done_o)
		else $error("negative high time other than release accepted");
	a_release_period: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cmd_ok && release_req |=> cycle_us_o == $past(cycle_us_o))
		else $error("release changed the shared period");
	a_timer_refused: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		tmr_sync_ff && cmd_valid_i && cmd_channel_i >= 4'h5 && cmd_channel_i <= 4'h8 |=> cmd_refused_o)
		else $error("upper channel accepted while timer mode in use");
endmodule

// ### test/multichannel_hw_pwm_test.sv
// Self-checking bench for the multichannel pulse-width generator
module multichannel_hw_pwm_test;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus and observed signals
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	logic timer_irq_mode_i = 1'b0;
	logic [3:0] cmd_channel_i = 4'h0;
	pwm_pkg::us_time_type cmd_cycle_us_i = 16'h0000;
	logic [16:0] cmd_high_us_i = 17'h00000;
	logic cmd_done_o, cmd_refused_o, done_r, refused_r;
	pwm_pkg::us_time_type cycle_us_o;
	logic [7:0] pwm_o, pin_function_select_o, sel_r;
	int fails = 0;
	int checked = 0;
	int seed = 92;
	int ch, per, hi;
	// Full variant and reduced variant see the same commands
	multichannel_hw_pwm dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
		.cmd_channel_i(cmd_channel_i), .cmd_cycle_us_i(cmd_cycle_us_i), .cmd_high_us_i(cmd_high_us_i),
		.timer_irq_mode_i(timer_irq_mode_i), .cmd_done_o(cmd_done_o), .cmd_refused_o(cmd_refused_o),
		.cycle_us_o(cycle_us_o), .pwm_o(pwm_o), .pin_function_select_o(pin_function_select_o));
	multichannel_hw_pwm #(.REDUCED_VARIANT(1'b1)) dut_reduced (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.cmd_valid_i(cmd_valid_i), .cmd_channel_i(cmd_channel_i), .cmd_cycle_us_i(cmd_cycle_us_i),
		.cmd_high_us_i(cmd_high_us_i), .timer_irq_mode_i(timer_irq_mode_i), .cmd_done_o(done_r),
		.cmd_refused_o(refused_r), .cycle_us_o(), .pwm_o(), .pin_function_select_o(sel_r));
	// Clock at 20 MHz
	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	task check(input logic [39:0] seen, input logic [39:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("Checks %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// One command word, 1 ns after an edge; an idle edge first keeps strobes apart
	task cmd(input int c, input int p, input int h, input logic ok);
		@(posedge clk_sys_i);
		#1 cmd_valid_i = 1'b1;
		cmd_channel_i = c[3:0];
		cmd_cycle_us_i = p[15:0];
		cmd_high_us_i = h[16:0];
		@(posedge clk_sys_i);
		#1 cmd_valid_i = 1'b0;
		check(cmd_done_o, ok);
		check(cmd_refused_o, !ok);
	endtask
	// Expected high cycles over two periods, 20 clocks per microsecond
	function automatic int exp_high(input int p, input int h);
		return ((h >= p) ? p : h) * 20 * 2;
	endfunction
	// Skip one tick so a shortened period has wrapped, then count whole periods
	task measure(input int c, input int p, input int h);
		logic [39:0] n;
		n = 40'h0;
		repeat (20) @(posedge clk_sys_i);
		repeat (p * 40) begin
			@(posedge clk_sys_i);
			#1 n += pwm_o[c-1];
		end
		check(n, exp_high(p, h));
	endtask
	task reset_check(input int cycles);
		rst_i = 1'b1;
		repeat (cycles) @(posedge clk_sys_i);
		#1 check({cmd_done_o, cmd_refused_o, cycle_us_o, pwm_o, pin_function_select_o}, 40'h0);
		rst_i = 1'b0;
	endtask
	// Watchdog sized well beyond the longest expected run
	initial begin
		#(50 * 60000);
		fails++;
		complete_run;
	end
	// Main sequence
	initial begin
		reset_check(16);
		$display("reset done");
		cmd(2, 4, 1, 1'b1);
		check(cycle_us_o, 16'h0004);
		check(pin_function_select_o, 8'h02);
		measure(2, 4, 1);
		measure(2, 4, 1);
		cmd(3, 8, 0, 1'b1);
		check(cycle_us_o, 16'h0008);
		measure(3, 8, 0);
		cmd(1, 8, 8, 1'b1);
		measure(1, 8, 8);
		cmd(2, 5, -1, 1'b1);
		check(cycle_us_o, 16'h0008);
		check(pin_function_select_o[1], 1'b0);
		measure(2, 8, 0);
		$display("waveform tests done");
		// Bad channel numbers and a negative high time other than release
		cmd(0, 4, 1, 1'b0);
		cmd(9, 4, 1, 1'b0);
		cmd(15, 4, 1, 1'b0);
		cmd(3, 4, -2, 1'b0);
		check(cycle_us_o, 16'h0008);
		cmd(4, 4, 1, 1'b1);
		check(refused_r, 1'b1);
		cmd(6, 4, 2, 1'b1);
		check(refused_r, 1'b1);
		check(sel_r, 8'h05);
		cmd(8, 4, 2, 1'b1);
		check(done_r, 1'b1);
		$display("refusal tests done");
		// Timer mode takes channels 5..8 away and gives them back
		timer_irq_mode_i = 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1 check(pin_function_select_o[7], 1'b0);
		cmd(5, 4, 1, 1'b0);
		cmd(4, 4, 1, 1'b1);
		timer_irq_mode_i = 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1 check(pin_function_select_o[7], 1'b1);
		measure(8, 4, 2);
		$display("timer mode tests done");
		// Random programming of all channels
		repeat (12) begin
			ch = 1 + {$random(seed)} % 8;
			per = 2 + {$random(seed)} % 9;
			hi = {$random(seed)} % (per + 1);
			cmd(ch, per, hi, 1'b1);
			check(cycle_us_o, per);
			check(pin_function_select_o[ch-1], 1'b1);
			measure(ch, per, hi);
		end
		$display("random tests done");
		reset_check(2);
		$display("second reset done");
		complete_run;
	end
endmodule
